// ===== rss_pkg.sv
// Shared types and constants for the rotate, subtract and sleep execution block.
package rss_pkg;

	localparam int RSS_DATA_W = 8;
	localparam int RSS_ADDR_W = 7;
	localparam int RSS_NIB_W = 4;

	localparam logic RSS_DEST_ACC = 1'h0;
	localparam logic RSS_DEST_FILE = 1'h1;

	localparam logic [RSS_DATA_W-1:0] RSS_ACC_RST = 8'h00;
	localparam logic RSS_CARRY_RST = 1'h0;
	localparam logic RSS_HALF_RST = 1'h0;
	localparam logic RSS_ZERO_RST = 1'h0;
	// Both status flags read high after a power-on start.
	localparam logic RSS_EXPIRY_RST = 1'h1;
	localparam logic RSS_PDOWN_RST = 1'h1;

	typedef enum logic [2:0] {
		RSS_OP_ROTATE,
		RSS_OP_SUB_LIT,
		RSS_OP_SUB_FILE,
		RSS_OP_SUB_FILE_BORROW,
		RSS_OP_SLEEP
	} rss_op_t;

	typedef struct packed {
		rss_op_t op;
		logic [RSS_DATA_W-1:0] literal;
		logic [RSS_ADDR_W-1:0] file_addr;
		logic dest;
	} rss_req_t;

	typedef struct packed {
		logic carry;
		logic half_borrow_flag;
		logic zero;
		logic watchdog_expiry_flag;
		logic power_down_flag;
	} rss_flags_t;

	typedef struct packed {
		logic [RSS_DATA_W-1:0] result;
		logic carry;
		logic half_borrow_flag;
	} rss_sub_t;

endpackage : rss_pkg

// ===== rss_exec.sv
// Execution unit for rotate-right, the three subtract forms and sleep.
`timescale 1ns/1ps
module rss_exec
	import rss_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic EXEC_VALID,
	input wire rss_req_t EXEC_REQ,
	input wire logic [RSS_DATA_W-1:0] FILE_RD_DATA,
	input wire logic WAKE,
	output logic EXEC_READY,
	output logic [RSS_DATA_W-1:0] ACC,
	output logic FILE_WR_EN,
	output logic [RSS_ADDR_W-1:0] FILE_WR_ADDR,
	output logic [RSS_DATA_W-1:0] FILE_WR_DATA,
	output rss_flags_t FLAGS,
	output logic WATCHDOG_CLEAR,
	output logic OSC_RUN
);

	// ****************************************
	// Arithmetic
	// ****************************************

	// Subtraction as a + ~b + cin; the carry out is the active-low borrow.
	function automatic rss_sub_t sub_borrow(input logic [RSS_DATA_W-1:0] a,
			input logic [RSS_DATA_W-1:0] b, input logic cin);
		logic [RSS_DATA_W:0] full;
		logic [RSS_NIB_W:0] low;
		rss_sub_t r;
		full = {1'h0, a} + {1'h0, ~b} + {{RSS_DATA_W{1'h0}}, cin};
		low = {1'h0, a[RSS_NIB_W-1:0]} + {1'h0, ~b[RSS_NIB_W-1:0]} + {{RSS_NIB_W{1'h0}}, cin};
		r.result = full[RSS_DATA_W-1:0];
		r.carry = full[RSS_DATA_W];
		r.half_borrow_flag = low[RSS_NIB_W];
		return r;
	endfunction : sub_borrow

	typedef enum logic {RSS_RUN, RSS_SLEEPING} rss_state_t;

	rss_state_t state_q, state_d;
	logic [RSS_DATA_W-1:0] acc_q, acc_d;
	logic [RSS_DATA_W-1:0] wr_data_q, wr_data_d;
	logic [RSS_ADDR_W-1:0] wr_addr_q, wr_addr_d;
	logic wr_en_q, wr_en_d;
	logic wdt_clr_q, wdt_clr_d;
	rss_flags_t flags_q, flags_d;
	logic take;
	rss_sub_t sub;
	logic [RSS_DATA_W-1:0] res;

	// Instructions are refused while asleep; only WAKE or a reset restarts the core.
	assign EXEC_READY = (state_q == RSS_RUN);
	assign take = EXEC_VALID && EXEC_READY;

	// ****************************************
	// Next state
	// ****************************************

	always_comb begin
		state_d = state_q;
		acc_d = acc_q;
		wr_data_d = wr_data_q;
		wr_addr_d = wr_addr_q;
		wr_en_d = 1'h0;
		wdt_clr_d = 1'h0;
		flags_d = flags_q;
		sub = '0;
		res = '0;
		unique case (EXEC_REQ.op)
			RSS_OP_SUB_LIT: sub = sub_borrow(EXEC_REQ.literal, acc_q, 1'h1);
			RSS_OP_SUB_FILE: sub = sub_borrow(FILE_RD_DATA, acc_q, 1'h1);
			RSS_OP_SUB_FILE_BORROW: sub = sub_borrow(FILE_RD_DATA, acc_q, flags_q.carry);
			default: sub = '0;
		endcase
		unique case (state_q)
			RSS_RUN: begin
				if (take) begin
					if (EXEC_REQ.op == RSS_OP_ROTATE) begin
						res = {flags_q.carry, FILE_RD_DATA[RSS_DATA_W-1:1]};
						flags_d.carry = FILE_RD_DATA[0];
					end else if (EXEC_REQ.op == RSS_OP_SLEEP) begin
						flags_d.power_down_flag = 1'h0;
						flags_d.watchdog_expiry_flag = 1'h1;
						wdt_clr_d = 1'h1;
						state_d = RSS_SLEEPING;
					end else begin
						res = sub.result;
						flags_d.carry = sub.carry;
						flags_d.half_borrow_flag = sub.half_borrow_flag;
						flags_d.zero = (sub.result == '0);
					end
					if (EXEC_REQ.op == RSS_OP_SUB_LIT) begin
						acc_d = res;
					end else if (EXEC_REQ.op != RSS_OP_SLEEP) begin
						if (EXEC_REQ.dest == RSS_DEST_FILE) begin
							wr_en_d = 1'h1;
							wr_addr_d = EXEC_REQ.file_addr;
							wr_data_d = res;
						end else begin
							acc_d = res;
						end
					end
				end
			end
			RSS_SLEEPING: begin
				if (WAKE) begin
					state_d = RSS_RUN;
				end
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			state_q <= RSS_RUN;
			acc_q <= RSS_ACC_RST;
			wr_data_q <= '0;
			wr_addr_q <= '0;
			wr_en_q <= 1'h0;
			wdt_clr_q <= 1'h0;
			flags_q <= '{carry: RSS_CARRY_RST, half_borrow_flag: RSS_HALF_RST,
				zero: RSS_ZERO_RST, watchdog_expiry_flag: RSS_EXPIRY_RST,
				power_down_flag: RSS_PDOWN_RST};
		end else begin
			state_q <= state_d;
			acc_q <= acc_d;
			wr_data_q <= wr_data_d;
			wr_addr_q <= wr_addr_d;
			wr_en_q <= wr_en_d;
			wdt_clr_q <= wdt_clr_d;
			flags_q <= flags_d;
		end
	end

	assign ACC = acc_q;
	assign FILE_WR_EN = wr_en_q;
	assign FILE_WR_ADDR = wr_addr_q;
	assign FILE_WR_DATA = wr_data_q;
	assign FLAGS = flags_q;
	assign WATCHDOG_CLEAR = wdt_clr_q;
	// Gating the oscillator from a flop keeps glitches off the clock enable.
	assign OSC_RUN = (state_q == RSS_RUN);

	// ****************************************
	// Assertions
	// ****************************************

	sequence s_take(rss_op_t o);
		EXEC_VALID && EXEC_READY && EXEC_REQ.op == o;
	endsequence

	sequence s_sleep_done;
		!FLAGS.power_down_flag && FLAGS.watchdog_expiry_flag && WATCHDOG_CLEAR && !OSC_RUN;
	endsequence

	property p_rot_value;
		@(posedge CLOCK) disable iff (!RST_N)
		s_take(RSS_OP_ROTATE) |=> FLAGS.carry == $past(FILE_RD_DATA[0])
			&& (FILE_WR_EN ? FILE_WR_DATA : ACC)
			== {$past(FLAGS.carry), $past(FILE_RD_DATA[RSS_DATA_W-1:1])};
	endproperty
	a_rot_value: assert property (p_rot_value) else $error("rotate result wrong");

	property p_rot_keep;
		@(posedge CLOCK) disable iff (!RST_N)
		s_take(RSS_OP_ROTATE) |=> $stable(FLAGS.zero) && $stable(FLAGS.half_borrow_flag)
			&& $stable(FLAGS.power_down_flag);
	endproperty
	a_rot_keep: assert property (p_rot_keep) else $error("rotate changed a flag");

	property p_dest_file;
		@(posedge CLOCK) disable iff (!RST_N)
		take && EXEC_REQ.op != RSS_OP_SUB_LIT && EXEC_REQ.op != RSS_OP_SLEEP
			&& EXEC_REQ.dest == RSS_DEST_FILE
			|=> FILE_WR_EN && FILE_WR_ADDR == $past(EXEC_REQ.file_addr) && $stable(ACC)
			##1 (!FILE_WR_EN || $past(take));
	endproperty
	a_dest_file: assert property (p_dest_file) else $error("file write missing");

	property p_dest_acc;
		@(posedge CLOCK) disable iff (!RST_N)
		take && EXEC_REQ.op != RSS_OP_SLEEP && EXEC_REQ.dest == RSS_DEST_ACC |=> !FILE_WR_EN;
	endproperty
	a_dest_acc: assert property (p_dest_acc) else $error("unexpected file write");

	property p_sub_lit;
		@(posedge CLOCK) disable iff (!RST_N)
		s_take(RSS_OP_SUB_LIT) |=> ACC == RSS_DATA_W'($past(EXEC_REQ.literal) - $past(ACC))
			&& !FILE_WR_EN;
	endproperty
	a_sub_lit: assert property (p_sub_lit) else $error("literal subtract wrong");

	property p_sub_lit_flags;
		@(posedge CLOCK) disable iff (!RST_N)
		s_take(RSS_OP_SUB_LIT) |=> FLAGS.carry == ($past(ACC) <= $past(EXEC_REQ.literal))
			&& FLAGS.half_borrow_flag == ($past(ACC[3:0]) <= $past(EXEC_REQ.literal[3:0]));
	endproperty
	a_sub_lit_flags: assert property (p_sub_lit_flags) else $error("literal flags wrong");

	property p_sub_file;
		@(posedge CLOCK) disable iff (!RST_N)
		s_take(RSS_OP_SUB_FILE) |=> (FILE_WR_EN ? FILE_WR_DATA : ACC)
			== RSS_DATA_W'($past(FILE_RD_DATA) - $past(ACC))
			&& FLAGS.carry == ($past(ACC) <= $past(FILE_RD_DATA))
			&& FLAGS.half_borrow_flag == ($past(ACC[3:0]) <= $past(FILE_RD_DATA[3:0]));
	endproperty
	a_sub_file: assert property (p_sub_file) else $error("file subtract wrong");

	property p_sub_borrow;
		@(posedge CLOCK) disable iff (!RST_N)
		s_take(RSS_OP_SUB_FILE_BORROW) |=> (FILE_WR_EN ? FILE_WR_DATA : ACC)
			== RSS_DATA_W'($past(FILE_RD_DATA) - $past(ACC) - {7'h00, !$past(FLAGS.carry)});
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow subtract wrong");

	property p_sleep;
		@(posedge CLOCK) disable iff (!RST_N)
		s_take(RSS_OP_SLEEP) |=> (s_sleep_done
			and ($stable(FLAGS.carry) && $stable(FLAGS.zero) && $stable(ACC)))
			##1 !WATCHDOG_CLEAR;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry wrong");

	property p_asleep;
		@(posedge CLOCK) disable iff (!RST_N)
		!OSC_RUN && !WAKE |=> !OSC_RUN && !EXEC_READY && !FILE_WR_EN;
	endproperty
	a_asleep: assert property (p_asleep) else $error("woke without cause");

	property p_zero;
		@(posedge CLOCK) disable iff (!RST_N)
		take && EXEC_REQ.op inside {RSS_OP_SUB_LIT, RSS_OP_SUB_FILE, RSS_OP_SUB_FILE_BORROW}
			|=> FLAGS.zero == ((FILE_WR_EN ? FILE_WR_DATA : ACC) == '0);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule : rss_exec

// ===== test_rss_exec.sv
// Self-checking testbench for the rotate, subtract and sleep execution block.
`timescale 1ns/1ps
module test_rss_exec
	import rss_pkg::*;
;
	// ****************************************
	// Signals and device under test
	// ****************************************
	logic clock;
	logic rst_n;
	logic exec_valid;
	rss_req_t exec_req;
	logic [RSS_DATA_W-1:0] file_rd_data;
	logic wake;
	logic exec_ready;
	logic [RSS_DATA_W-1:0] acc;
	logic file_wr_en;
	logic [RSS_ADDR_W-1:0] file_wr_addr;
	logic [RSS_DATA_W-1:0] file_wr_data;
	rss_flags_t flags;
	logic watchdog_clear;
	logic osc_run;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [7:0] acc_m = 8'h00;
	logic c_m = 1'h0;
	logic h_m = 1'h0;
	logic z_m = 1'h0;

	rss_exec i_rss_exec (
		.CLOCK(clock), .RST_N(rst_n), .EXEC_VALID(exec_valid), .EXEC_REQ(exec_req),
		.FILE_RD_DATA(file_rd_data), .WAKE(wake), .EXEC_READY(exec_ready), .ACC(acc),
		.FILE_WR_EN(file_wr_en), .FILE_WR_ADDR(file_wr_addr), .FILE_WR_DATA(file_wr_data),
		.FLAGS(flags), .WATCHDOG_CLEAR(watchdog_clear), .OSC_RUN(osc_run)
	);

	initial begin
		clock = 1'h0;
		forever #10 clock = ~clock;
	end

	// ****************************************
	// Checking and driving tasks
	// ****************************************
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	// Every run is about 52 cycles, so this ceiling only trips on a hang.
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			tally_and_finish;
		end
	end

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_byte

	task automatic chk_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	// The model works from the borrow-free sum a + ~b + cin, so carry and half
	// come straight from the adder carries rather than from the comparisons.
	task automatic run_op(input rss_op_t op, input logic [7:0] lit, input logic [7:0] f,
		input logic dest);
		logic [8:0] t;
		logic [4:0] n;
		logic [7:0] a;
		logic cin;
		logic wr;
		logic [6:0] addr;
		addr = f[6:0] ^ 7'h2A;
		a = (op == RSS_OP_SUB_LIT) ? lit : f;
		cin = (op == RSS_OP_SUB_FILE_BORROW) ? c_m : 1'h1;
		t = {1'h0, a} + {1'h0, ~acc_m} + {8'h00, cin};
		n = {1'h0, a[3:0]} + {1'h0, ~acc_m[3:0]} + {4'h0, cin};
		wr = dest && (op != RSS_OP_SUB_LIT);
		if (op == RSS_OP_ROTATE) begin
			t = {f[0], c_m, f[7:1]};
			n = {h_m, 4'h0};
		end else begin
			z_m = (t[7:0] == 8'h00);
		end
		c_m = t[8];
		h_m = n[4];
		if (!wr) begin
			acc_m = t[7:0];
		end
		@(posedge clock);
		exec_valid <= 1'h1;
		exec_req <= '{op: op, literal: lit, file_addr: addr, dest: dest};
		file_rd_data <= f;
		@(posedge clock);
		exec_valid <= 1'h0;
		#1;
		chk_byte("acc", acc_m, acc);
		chk_bit("write enable", wr, file_wr_en);
		if (wr) begin
			chk_byte("write data", t[7:0], file_wr_data);
			chk_byte("write addr", {1'h0, addr}, {1'h0, file_wr_addr});
		end
		chk_bit("carry", c_m, flags.carry);
		chk_bit("half", h_m, flags.half_borrow_flag);
		chk_bit("zero", z_m, flags.zero);
	endtask : run_op

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		#1;
		chk_byte("acc", 8'h00, acc);
		chk_bit("expiry", 1'h1, flags.watchdog_expiry_flag);
		chk_bit("power down", 1'h1, flags.power_down_flag);
		chk_bit("osc", 1'h1, osc_run);
		chk_bit("ready", 1'h1, exec_ready);
		$display("test reset done");
	endtask : t_reset

	task automatic t_rotate;
		run_op(RSS_OP_ROTATE, 8'h00, 8'h01, RSS_DEST_ACC);
		run_op(RSS_OP_ROTATE, 8'h00, 8'h80, RSS_DEST_FILE);
		$display("test rotate done");
	endtask : t_rotate

	task automatic t_sub_lit;
		logic [7:0] k[4] = '{8'h00, 8'h35, 8'h34, 8'hFF};
		foreach (k[i]) begin
			run_op(RSS_OP_SUB_LIT, k[i], 8'hA5, RSS_DEST_FILE);
		end
		$display("test literal subtract done");
	endtask : t_sub_lit

	task automatic t_sub_file;
		run_op(RSS_OP_SUB_LIT, 8'h18, 8'h00, RSS_DEST_ACC);
		run_op(RSS_OP_SUB_FILE, 8'h00, 8'h20, RSS_DEST_FILE);
		run_op(RSS_OP_SUB_FILE, 8'h00, 8'h17, RSS_DEST_ACC);
		run_op(RSS_OP_SUB_FILE, 8'h00, 8'hFF, RSS_DEST_ACC);
		$display("test file subtract done");
	endtask : t_sub_file

	task automatic t_borrow;
		run_op(RSS_OP_ROTATE, 8'h00, 8'h01, RSS_DEST_FILE);
		run_op(RSS_OP_SUB_FILE_BORROW, 8'h00, 8'h10, RSS_DEST_FILE);
		run_op(RSS_OP_ROTATE, 8'h00, 8'h00, RSS_DEST_FILE);
		run_op(RSS_OP_SUB_FILE_BORROW, 8'h00, 8'h01, RSS_DEST_ACC);
		$display("test borrow subtract done");
	endtask : t_borrow

	task automatic t_sleep;
		@(posedge clock);
		exec_valid <= 1'h1;
		exec_req.op <= RSS_OP_SLEEP;
		@(posedge clock);
		// A distinct literal makes a request wrongly taken while asleep show in the accumulator.
		exec_req <= '{op: RSS_OP_SUB_LIT, literal: 8'h5A, file_addr: 7'h00, dest: RSS_DEST_ACC};
		#1;
		chk_bit("power down", 1'h0, flags.power_down_flag);
		chk_bit("expiry", 1'h1, flags.watchdog_expiry_flag);
		chk_bit("carry", c_m, flags.carry);
		chk_bit("wd clear", 1'h1, watchdog_clear);
		chk_bit("osc", 1'h0, osc_run);
		chk_bit("ready", 1'h0, exec_ready);
		repeat (3) @(posedge clock);
		#1;
		chk_bit("wd clear", 1'h0, watchdog_clear);
		chk_bit("osc", 1'h0, osc_run);
		chk_byte("acc", acc_m, acc);
		@(posedge clock);
		wake <= 1'h1;
		@(posedge clock);
		wake <= 1'h0;
		#1;
		chk_bit("osc", 1'h1, osc_run);
		chk_bit("ready", 1'h1, exec_ready);
		chk_bit("power down", 1'h0, flags.power_down_flag);
		// The request held through sleep is taken at the first edge after waking.
		@(posedge clock);
		exec_valid <= 1'h0;
		#1;
		chk_byte("acc", 8'h5A, acc);
		chk_bit("carry", 1'h1, flags.carry);
		chk_bit("half", 1'h1, flags.half_borrow_flag);
		chk_bit("zero", 1'h0, flags.zero);
		$display("test sleep done");
	endtask : t_sleep

	initial begin
		rst_n = 1'h0;
		exec_valid = 1'h0;
		exec_req = '0;
		file_rd_data = 8'h00;
		wake = 1'h0;
		repeat (16) @(posedge clock);
		rst_n <= 1'h1;
		t_reset;
		t_rotate;
		t_sub_lit;
		t_sub_file;
		t_borrow;
		t_sleep;
		tally_and_finish;
	end
endmodule : test_rss_exec
